/* speed_cmd_consts.svh */
// Constants for the speed command select block: offsets, reset values, limits and timing.
`ifndef SPEED_CMD_CONSTS_SVH
`define SPEED_CMD_CONSTS_SVH

`define ADDR_W                 16
`define OFS_POS_FF_GAIN        16'h012C
`define OFS_POS_P_GAIN         16'h0130
`define OFS_SPEED_REG_1        16'h0200
`define OFS_SPEED_REG_2        16'h0204
`define OFS_SPEED_REG_3        16'h0208
`define OFS_ANALOG_MAX_SPEED   16'h020C
`define OFS_MODE_CTRL          16'h0210
`define OFS_STATUS             16'h0214
`define OFS_SMOOTH_STEP        16'h0218
`define RST_POS_FF_GAIN        16'h0032
`define RST_POS_P_GAIN         16'h007D
`define MAX_POS_FF_GAIN        16'h0064
`define MAX_POS_P_GAIN         16'h07FF
`define SPEED_LIMIT_POS        32'sh0000C350
`define SPEED_LIMIT_NEG        (-32'sh0000C350)
`define RST_ANALOG_MAX_SPEED   16'h7530
`define RST_SMOOTH_STEP        16'h0064
`define RST_SMOOTH_ENABLE      1'b1
`define MODE_AUTO_BIT          0
`define MODE_SMOOTH_BIT        1
`define STAT_SRC_LSB           0
`define STAT_SRC_MSB           1
`define STAT_NO_ANALOG_BIT     2
`define STAT_TORQUE_BIT        3
`define CLK_HZ                 25000000
`define SMOOTH_TICK_US         100
`define SMOOTH_TICK_CYC        ((`CLK_HZ / 1000000) * `SMOOTH_TICK_US)

`endif

/* speed_cmd_pkg.sv */
// Types shared by the speed command select block.
package speed_cmd_pkg;
  typedef enum logic [1:0] {
    SRC_ANALOG,
    SRC_REG1,
    SRC_REG2,
    SRC_REG3
  } speed_src_t;

  typedef enum logic {
    GAIN_MANUAL,
    GAIN_AUTO
  } gain_mode_t;
endpackage

/* analog_speed_scale.sv */
// Linear scaling of the signed analog command code to a speed in 0.1 r/min counts.
`timescale 1ns/10ps
module analog_speed_scale #(
  parameter int ADC_W = 16
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_sync_n,
  input  wire logic signed [ADC_W-1:0] adc_code,
  input  wire logic        [15:0]      max_speed_rpm,
  output logic signed      [31:0]      speed_out
);
  typedef struct packed {
    logic signed [31:0] speed;
  } scale_state_t;

  scale_state_t st_r;
  scale_state_t st_nxt;
  logic signed [ADC_W+20:0] prod;

  // Full-scale code (plus or minus ten volts) maps to the maximum speed, in 0.1 r/min units.
  always_comb begin
    st_nxt = st_r;
    prod = (ADC_W+21)'(adc_code * $signed({1'b0, max_speed_rpm}) * 10);
    st_nxt.speed = 32'(prod >>> (ADC_W-1));
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign speed_out = st_r.speed;
endmodule

/* speed_smoother.sv */
// Ramp limiter that eases steps between internal speed commands.
`timescale 1ns/10ps
`include "speed_cmd_consts.svh"
module speed_smoother (
  input  wire logic               clk_sys,
  input  wire logic               rst_sync_n,
  input  wire logic               bypass,
  input  wire logic signed [31:0] target,
  input  wire logic        [15:0] step,
  output logic signed      [31:0] speed_out
);
  typedef struct packed {
    logic signed [31:0] speed;
    logic        [15:0] tick_cnt;
    logic signed [31:0] last_target;
  } smooth_state_t;

  smooth_state_t st_r;
  smooth_state_t st_nxt;
  logic          tick;
  logic signed [31:0] diff;
  logic signed [31:0] stp;
  logic               retarget;
  logic               step_now;

  assign tick = (st_r.tick_cnt == 16'(`SMOOTH_TICK_CYC - 1));
  // A new target restarts the divider and steps at once, so a fresh selection never waits out a tick.
  assign retarget = (target != st_r.last_target);
  assign step_now = tick || retarget;

  // A ramp rather than a true three-phase profile keeps area small while still removing the jump.
  always_comb begin
    st_nxt = st_r;
    diff = target - st_r.speed;
    stp = $signed({16'h0000, step});
    st_nxt.last_target = target;
    st_nxt.tick_cnt = step_now ? 16'h0000 : st_r.tick_cnt + 16'h0001;
    if (bypass) begin
      st_nxt.speed = target;
    end else if (step_now) begin
      if (diff > stp) begin
        st_nxt.speed = st_r.speed + stp;
      end else if (diff < -stp) begin
        st_nxt.speed = st_r.speed - stp;
      end else begin
        st_nxt.speed = target;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign speed_out = st_r.speed;
endmodule

/* servo_speed_command_select.sv */
// Speed command source selection, internal speed registers and position loop gain parameters.
//
// Summary of operation
// - Speed mode with analog, both selects 0: command comes from analog voltage.
// - No-analog speed mode, both selects 0: command is forced to zero.
// - Any select nonzero: an internal speed register drives the command.
// - Select 01, 10, 11 choose registers one, two, three respectively.
// - A new select reaches active_source two clocks later via the two-flop synchroniser; speed_command three clocks later for analog, four for registers.
// - Internal speed registers hold signed -50000..50000 in 0.1 r/min units.
// - Select line open reads 0, closed reads 1.
// - In torque mode the selected command becomes the speed limit.
// - Host may rewrite speed registers; register switches are smoothed.
// - Manual gain mode uses user gains only, no auto tuning.
// - Automatic gain mode estimates inertia, user gains are starting values.
// - Position proportional gain: 16 bits, 0..2047, resets to 125.
// - Position feed-forward gain: 16 bits, 0..100, resets to 50, at 012CH.
// - Analog voltage scaled to speed by a maximum-speed parameter.
`timescale 1ns/10ps
`include "speed_cmd_consts.svh"
module servo_speed_command_select
  import speed_cmd_pkg::*;
#(
  parameter int ADC_W = 16
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    speed_select_low,
  input  wire logic                    speed_select_high,
  input  wire logic                    speed_mode_no_analog,
  input  wire logic                    torque_mode,
  input  wire logic signed [ADC_W-1:0] analog_ref_code,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [`ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]             reg_wdata,
  output logic [31:0]                  reg_rdata,
  output logic signed [31:0]           speed_command,
  output logic signed [31:0]           speed_limit,
  output logic                         speed_limit_valid,
  output logic [15:0]                  position_proportional_gain,
  output logic [15:0]                  position_feedforward_gain,
  output logic                         auto_tuning_enable,
  output logic [1:0]                   active_source
);
  typedef struct packed {
    logic [1:0]         sel_meta;
    logic [1:0]         sel_sync;
    logic signed [31:0] internal_speed_reg_1;
    logic signed [31:0] internal_speed_reg_2;
    logic signed [31:0] internal_speed_reg_3;
    logic [15:0]        analog_max_speed_scale;
    logic [15:0]        smooth_step;
    logic [15:0]        pos_gain_param;
    logic [15:0]        pos_ff_param;
    gain_mode_t         gain_tuning_mode_param;
    logic               smooth_enable;
    logic [31:0]        rdata;
    // Command outputs are registered so downstream loops never see a glitch from the mode inputs.
    logic signed [31:0] speed_cmd;
    logic signed [31:0] speed_lim;
    logic               lim_valid;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;
  logic       rst_sync_n;
  speed_src_t src;
  logic signed [31:0] analog_speed;
  logic signed [31:0] reg_target;
  logic signed [31:0] smoothed_speed;
  logic signed [31:0] cmd_sel;
  logic               smooth_bypass;
  logic signed [31:0] wval;
  logic [31:0]        mode_word;
  logic [31:0]        status_word;

  // Reset synchroniser lives in its own flop pair so release is clean for all other state.
  logic [1:0] rst_pipe_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_r[1];

  function automatic logic signed [31:0] clamp_speed(input logic signed [31:0] v);
    if (v > `SPEED_LIMIT_POS) begin
      clamp_speed = `SPEED_LIMIT_POS;
    end else if (v < `SPEED_LIMIT_NEG) begin
      clamp_speed = `SPEED_LIMIT_NEG;
    end else begin
      clamp_speed = v;
    end
  endfunction

  // Select code: high line first, low line second; a closed contact reads 1.
  always_comb begin
    case (st_r.sel_sync)
      2'h1:    src = SRC_REG1;
      2'h2:    src = SRC_REG2;
      2'h3:    src = SRC_REG3;
      default: src = SRC_ANALOG;
    endcase
  end

  always_comb begin
    case (src)
      SRC_REG1: reg_target = st_r.internal_speed_reg_1;
      SRC_REG2: reg_target = st_r.internal_speed_reg_2;
      SRC_REG3: reg_target = st_r.internal_speed_reg_3;
      default:  reg_target = 32'sh00000000;
    endcase
  end

  // Smoothing only applies to register sources; analog commands follow directly.
  assign smooth_bypass = (src == SRC_ANALOG) || !st_r.smooth_enable;

  always_comb begin
    if (src != SRC_ANALOG) begin
      cmd_sel = smoothed_speed;
    end else if (speed_mode_no_analog) begin
      cmd_sel = 32'sh00000000;
    end else begin
      cmd_sel = analog_speed;
    end
  end

  assign wval = $signed(reg_wdata);

  // Read-back words are built field by field so the bit map lives in the constants header only.
  always_comb begin
    mode_word                                = 32'h00000000;
    mode_word[`MODE_AUTO_BIT]                = (st_r.gain_tuning_mode_param == GAIN_AUTO);
    mode_word[`MODE_SMOOTH_BIT]              = st_r.smooth_enable;
    status_word                              = 32'h00000000;
    status_word[`STAT_SRC_MSB:`STAT_SRC_LSB] = src;
    status_word[`STAT_NO_ANALOG_BIT]         = speed_mode_no_analog;
    status_word[`STAT_TORQUE_BIT]            = torque_mode;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sel_meta = {speed_select_high, speed_select_low};
    st_nxt.sel_sync = st_r.sel_meta;
    st_nxt.speed_cmd = torque_mode ? 32'sh00000000 : cmd_sel;
    st_nxt.speed_lim = cmd_sel;
    st_nxt.lim_valid = torque_mode;
    if (reg_wr) begin
      case (reg_addr)
        `OFS_SPEED_REG_1:      st_nxt.internal_speed_reg_1 = clamp_speed(wval);
        `OFS_SPEED_REG_2:      st_nxt.internal_speed_reg_2 = clamp_speed(wval);
        `OFS_SPEED_REG_3:      st_nxt.internal_speed_reg_3 = clamp_speed(wval);
        `OFS_ANALOG_MAX_SPEED: st_nxt.analog_max_speed_scale = reg_wdata[15:0];
        `OFS_SMOOTH_STEP:      st_nxt.smooth_step = reg_wdata[15:0];
        `OFS_POS_P_GAIN: begin
          if (reg_wdata[15:0] <= `MAX_POS_P_GAIN) begin
            st_nxt.pos_gain_param = reg_wdata[15:0];
          end
        end
        `OFS_POS_FF_GAIN: begin
          if (reg_wdata[15:0] <= `MAX_POS_FF_GAIN) begin
            st_nxt.pos_ff_param = reg_wdata[15:0];
          end
        end
        `OFS_MODE_CTRL: begin
          st_nxt.gain_tuning_mode_param = gain_mode_t'(reg_wdata[`MODE_AUTO_BIT]);
          st_nxt.smooth_enable = reg_wdata[`MODE_SMOOTH_BIT];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `OFS_SPEED_REG_1:      st_nxt.rdata = st_r.internal_speed_reg_1;
        `OFS_SPEED_REG_2:      st_nxt.rdata = st_r.internal_speed_reg_2;
        `OFS_SPEED_REG_3:      st_nxt.rdata = st_r.internal_speed_reg_3;
        `OFS_ANALOG_MAX_SPEED: st_nxt.rdata = {16'h0000, st_r.analog_max_speed_scale};
        `OFS_SMOOTH_STEP:      st_nxt.rdata = {16'h0000, st_r.smooth_step};
        `OFS_POS_P_GAIN:       st_nxt.rdata = {16'h0000, st_r.pos_gain_param};
        `OFS_POS_FF_GAIN:      st_nxt.rdata = {16'h0000, st_r.pos_ff_param};
        `OFS_MODE_CTRL:        st_nxt.rdata = mode_word;
        `OFS_STATUS:           st_nxt.rdata = status_word;
        default:               st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r.sel_meta               <= 2'h0;
      st_r.sel_sync               <= 2'h0;
      st_r.internal_speed_reg_1   <= 32'sh00000000;
      st_r.internal_speed_reg_2   <= 32'sh00000000;
      st_r.internal_speed_reg_3   <= 32'sh00000000;
      st_r.analog_max_speed_scale <= `RST_ANALOG_MAX_SPEED;
      st_r.smooth_step            <= `RST_SMOOTH_STEP;
      st_r.pos_gain_param         <= `RST_POS_P_GAIN;
      st_r.pos_ff_param           <= `RST_POS_FF_GAIN;
      st_r.gain_tuning_mode_param <= GAIN_MANUAL;
      st_r.smooth_enable          <= `RST_SMOOTH_ENABLE;
      st_r.rdata                  <= 32'h00000000;
      st_r.speed_cmd              <= 32'sh00000000;
      st_r.speed_lim              <= 32'sh00000000;
      st_r.lim_valid              <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  analog_speed_scale #(
    .ADC_W(ADC_W)
  ) i_analog_speed_scale (
    .clk_sys      (clk_sys),
    .rst_sync_n   (rst_sync_n),
    .adc_code     (analog_ref_code),
    .max_speed_rpm(st_r.analog_max_speed_scale),
    .speed_out    (analog_speed)
  );

  speed_smoother i_speed_smoother (
    .clk_sys   (clk_sys),
    .rst_sync_n(rst_sync_n),
    .bypass    (smooth_bypass),
    .target    (reg_target),
    .step      (st_r.smooth_step),
    .speed_out (smoothed_speed)
  );

  assign reg_rdata                  = st_r.rdata;
  assign speed_command              = st_r.speed_cmd;
  assign speed_limit                = st_r.speed_lim;
  assign speed_limit_valid          = st_r.lim_valid;
  assign position_proportional_gain = st_r.pos_gain_param;
  assign position_feedforward_gain  = st_r.pos_ff_param;
  // Manual mode blocks every automatic tuning path; auto mode lets the estimator start from the user gains.
  assign auto_tuning_enable         = (st_r.gain_tuning_mode_param == GAIN_AUTO);
  assign active_source              = src;
endmodule

/* servo_speed_command_select_asserts.sv */
// Checker for the speed command select block, bound to its top module.
`timescale 1ns/10ps
`include "speed_cmd_consts.svh"
module servo_speed_command_select_asserts (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                speed_select_low,
  input wire logic                speed_select_high,
  input wire logic                speed_mode_no_analog,
  input wire logic                torque_mode,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [`ADDR_W-1:0]  reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic [31:0]         reg_rdata,
  input wire logic signed [31:0]  speed_command,
  input wire logic                speed_limit_valid,
  input wire logic [15:0]         position_proportional_gain,
  input wire logic [15:0]         position_feedforward_gain,
  input wire logic                auto_tuning_enable,
  input wire logic [1:0]          active_source
);
  // The internal reset and the select synchronisers lag the pin reset, so timing checks wait a few edges.
  logic [2:0] up_cnt_r;
  wire        up_ok = (up_cnt_r == 3'h7);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) up_cnt_r <= 3'h0;
    else if (!up_ok) up_cnt_r <= up_cnt_r + 3'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_src_follow_pins: assert property (
    up_ok |-> active_source == $past({speed_select_high, speed_select_low}, 2))
    else $error("Active source does not follow the select lines.");
  a_ff_gain_take: assert property (
    reg_wr && reg_addr == `OFS_POS_FF_GAIN && reg_wdata <= 32'h64 |=> position_feedforward_gain == $past(reg_wdata[15:0]))
    else $error("Feed-forward gain write lost.");
  a_p_gain_take: assert property (
    reg_wr && reg_addr == `OFS_POS_P_GAIN && reg_wdata <= 32'h7FF |=> position_proportional_gain == $past(reg_wdata[15:0]))
    else $error("Proportional gain write lost.");
  a_gain_in_range: assert property (
    position_proportional_gain <= `MAX_POS_P_GAIN && position_feedforward_gain <= `MAX_POS_FF_GAIN)
    else $error("Gain outside its range.");
  a_rd_ff_gain: assert property (
    reg_rd && reg_addr == `OFS_POS_FF_GAIN |=> reg_rdata == {16'h0000, $past(position_feedforward_gain)})
    else $error("Feed-forward gain read wrong.");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved without a read.");
  a_auto_by_write: assert property (
    $changed(auto_tuning_enable) |-> $past(reg_wr && reg_addr == `OFS_MODE_CTRL))
    else $error("Gain mode changed without a write.");
  a_no_analog_zero: assert property (
    (up_ok && speed_mode_no_analog && active_source == 2'h0 && !torque_mode)[*3] |-> speed_command == 32'sh0)
    else $error("No-analog command not zero.");
  a_torque_limit: assert property (
    (up_ok && torque_mode)[*3] |-> speed_limit_valid && speed_command == 32'sh0)
    else $error("Torque mode limit flags wrong.");
endmodule

bind servo_speed_command_select servo_speed_command_select_asserts i_servo_speed_command_select_asserts (
  .clk_sys, .rst_n, .speed_select_low, .speed_select_high, .speed_mode_no_analog, .torque_mode, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .speed_command, .speed_limit_valid, .position_proportional_gain,
  .position_feedforward_gain, .auto_tuning_enable, .active_source);

/* host_select_contacts.sv */
// Host-side contact model driving the two speed select lines.
`timescale 1ns/10ps
module host_select_contacts (
  input  wire logic [1:0] closed,
  output logic            speed_select_low,
  output logic            speed_select_high
);
  // Contacts switch at once; the block's own synchroniser absorbs the asynchronous edge.
  assign speed_select_low = closed[0];
  assign speed_select_high = closed[1];
endmodule

/* tb_servo_speed_command_select.sv */
// Self-checking bench for the speed command select block.
`timescale 1ns/10ps
`include "speed_cmd_consts.svh"
module tb_servo_speed_command_select;
  logic               clk_sys, rst_n, speed_mode_no_analog, torque_mode, reg_wr, reg_rd;
  logic               speed_select_low, speed_select_high, speed_limit_valid, auto_tuning_enable;
  logic [15:0]        reg_addr, position_proportional_gain, position_feedforward_gain;
  logic [31:0]        reg_wdata, reg_rdata;
  logic signed [15:0] analog_ref_code;
  logic signed [31:0] speed_command, speed_limit;
  logic [1:0]         active_source, closed;
  logic [31:0]        regv [1:3];
  int                 mismatches, samples_checked, cyc;

  servo_speed_command_select i_servo_speed_command_select (
    .clk_sys, .rst_n, .speed_select_low, .speed_select_high, .speed_mode_no_analog, .torque_mode,
    .analog_ref_code, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .speed_command, .speed_limit,
    .speed_limit_valid, .position_proportional_gain, .position_feedforward_gain, .auto_tuning_enable,
    .active_source);
  host_select_contacts i_host_select_contacts (.closed, .speed_select_low, .speed_select_high);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic close_out;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs about 2700 cycles; the ceiling leaves ample slack.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    {rst_n, reg_wr, reg_rd, torque_mode, speed_mode_no_analog} = 5'h00;
    {reg_addr, reg_wdata, analog_ref_code, closed} = '0;
    regv = '{32'h0000C350, 32'hFFFF3CB0, 32'h00003039};
    pause(6);
    rst_n = 1'b1;
    pause(3);
    rd(`OFS_POS_FF_GAIN, 32'h00000032);
    rd(`OFS_POS_P_GAIN, 32'h0000007D);
    rd(`OFS_MODE_CTRL, 32'h00000002);
    // Gain tuning mode is settled before the position gains.
    wr(`OFS_MODE_CTRL, 32'h00000001);
    chk({31'h0, auto_tuning_enable}, 32'h1);
    wr(`OFS_MODE_CTRL, 32'h00000000);
    chk({31'h0, auto_tuning_enable}, 32'h0);
    wr(`OFS_POS_FF_GAIN, 32'h00000064);
    wr(`OFS_POS_FF_GAIN, 32'h00000065);
    rd(`OFS_POS_FF_GAIN, 32'h00000064);
    wr(`OFS_POS_P_GAIN, 32'h000007FF);
    wr(`OFS_POS_P_GAIN, 32'h00000800);
    rd(`OFS_POS_P_GAIN, 32'h000007FF);
    chk({16'h0000, position_feedforward_gain}, 32'h00000064);
    // A modest proportional gain keeps the position loop well inside a quarter of the speed loop bandwidth.
    wr(`OFS_POS_P_GAIN, 32'h0000003F);
    chk({16'h0000, position_proportional_gain}, 32'h0000003F);
    wr(16'h0300, 32'h00001234);
    rd(16'h0300, 32'h00000000);
    wr(`OFS_SPEED_REG_3, 32'h0000EA60);
    rd(`OFS_SPEED_REG_3, 32'h0000C350);
    wr(`OFS_SPEED_REG_1, regv[1]);
    wr(`OFS_SPEED_REG_2, regv[2]);
    wr(`OFS_SPEED_REG_3, regv[3]);
    rd(`OFS_SPEED_REG_2, regv[2]);
    for (int k = 1; k < 4; k++) begin
      closed = 2'(k);
      pause(4);
      chk({30'h0, active_source}, 32'(k));
      chk(speed_command, regv[k]);
    end
    closed = 2'b00;
    speed_mode_no_analog = 1'b1;
    analog_ref_code = 16'sh4000;
    pause(4);
    chk(speed_command, 32'h00000000);
    rd(`OFS_STATUS, 32'h00000004);
    wr(`OFS_ANALOG_MAX_SPEED, 32'h000003E8);
    rd(`OFS_ANALOG_MAX_SPEED, 32'h000003E8);
    speed_mode_no_analog = 1'b0;
    pause(4);
    chk(speed_command, 32'h00001388);
    analog_ref_code = 16'sh8000;
    pause(4);
    chk(speed_command, 32'hFFFFD8F0);
    torque_mode = 1'b1;
    closed = 2'b01;
    pause(4);
    chk(speed_limit, regv[1]);
    chk({31'h0, speed_limit_valid}, 32'h1);
    chk(speed_command, 32'h00000000);
    rd(`OFS_STATUS, 32'h00000009);
    torque_mode = 1'b0;
    // A step of 65535 per tick cannot cover the full 100000 swing in one tick.
    wr(`OFS_SMOOTH_STEP, 32'h0000FFFF);
    wr(`OFS_MODE_CTRL, 32'h00000002);
    rd(`OFS_SMOOTH_STEP, 32'h0000FFFF);
    closed = 2'b10;
    // The first step lands as soon as the new selection is seen; the rest waits one full tick.
    pause(4);
    chk(speed_command, 32'hFFFFC351);
    pause(2400);
    chk(speed_command, 32'hFFFFC351);
    pause(200);
    chk(speed_command, regv[2]);
    close_out();
  end
endmodule
